//--- sfy_pkg.sv
// Shared constants and types for the supervisor flags and calendar year block
package sfy_pkg;

	localparam logic [7:0] ADDR_MONTH = 8'h07;
	localparam logic [7:0] ADDR_YEAR = 8'h08;
	localparam logic [7:0] ADDR_FLAGS = 8'h09;

	localparam int NUM_FLAGS = 4;
	localparam int FLAG_LSB = 4;
	localparam int FLAG_BACKUP_LOW = 0;
	localparam int FLAG_SUPPLY_FAIL = 1;
	localparam int FLAG_LATE_WD = 2;
	localparam int FLAG_EARLY_WD = 3;

	localparam logic [7:0] YEAR_RESET = 8'h00;
	localparam logic [7:0] MONTH_RESET = 8'h01;
	localparam logic [7:0] READ_ZERO = 8'h00;
	localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
	localparam logic [3:0] MONTH_TENS_MAX_UNITS = 4'h2;
	localparam logic [3:0] LOW_NIBBLE_ZERO = 4'h0;

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [7:0] addr;
		logic [7:0] wrData;
	} sfy_reg_req_t;

	typedef struct packed {
		logic earlyWdFault;
		logic lateWdFault;
		logic supplyBelowTrip;
		logic manualReset;
		logic onBackup;
		logic backupBelowMin;
	} sfy_supervisor_t;

endpackage : sfy_pkg

//--- sfy_sticky_flag.sv
// One retained status flag: hardware sets it, software clears it
`timescale 1ns/1ps
module sfy_sticky_flag
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic setPulse,
	input wire logic clrPulse,
	output logic flag
);

	logic flag_reg;

	// A set arriving with a clear wins, so no event is lost
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			flag_reg <= 1'b0;
		else if (setPulse)
			flag_reg <= 1'b1;
		else if (clrPulse)
			flag_reg <= 1'b0;
	end

	assign flag = flag_reg;

endmodule : sfy_sticky_flag

//--- sfy_supervisor_regs.sv
// Supervisor status flags and calendar month and year registers
//
// Operation
// - Supply-fail flag sets when reset output is active due to low main supply.
// - A manual reset request leaves the supply-fail flag unchanged.
// - Watchdog fault flags and supply-fail flag are independent; several may read set.
// - Supply-fail flag is retained, host read/write; device sets, host clears writing zero.
// - Backup-low flag sets when backup supply falls too low while running from it.
// - Month holds two BCD digits, range one to twelve, tens digit one bit.
`timescale 1ns/1ps
module sfy_supervisor_regs
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire sfy_pkg::sfy_reg_req_t regReq,
	output logic [7:0] regRdData,
	output logic regRdValid,
	input wire logic resetOutN,
	input wire sfy_pkg::sfy_supervisor_t sup,
	output logic [sfy_pkg::NUM_FLAGS-1:0] flagsOut
);

	logic [sfy_pkg::NUM_FLAGS-1:0] flagSet;
	logic [sfy_pkg::NUM_FLAGS-1:0] flagClr;
	logic [sfy_pkg::NUM_FLAGS-1:0] flagVec;
	logic [7:0] year_reg;
	logic [7:0] month_reg;
	logic [7:0] rdData_reg;
	logic rdValid_reg;
	logic wrFlags;
	logic supplyTripReset;

	function automatic logic monthValid(input logic [7:0] v);
		logic ok;
		ok = 1'b0;
		if (v[7:5] == 3'b000)
		begin
			if (!v[4])
				ok = (v[3:0] != sfy_pkg::LOW_NIBBLE_ZERO) && (v[3:0] <= sfy_pkg::BCD_MAX_DIGIT);
			else
				ok = (v[3:0] <= sfy_pkg::MONTH_TENS_MAX_UNITS);
		end
		return ok;
	endfunction : monthValid

	function automatic logic yearValid(input logic [7:0] v);
		return (v[7:4] <= sfy_pkg::BCD_MAX_DIGIT) && (v[3:0] <= sfy_pkg::BCD_MAX_DIGIT);
	endfunction : yearValid

	assign wrFlags = regReq.wrEn && (regReq.addr == sfy_pkg::ADDR_FLAGS);

	// Only a supply-caused reset counts; a manual reset alone does not trip this
	assign supplyTripReset = !resetOutN && sup.supplyBelowTrip;

	always_comb
	begin
		flagSet = '0;
		flagSet[sfy_pkg::FLAG_BACKUP_LOW] = sup.onBackup && sup.backupBelowMin;
		flagSet[sfy_pkg::FLAG_SUPPLY_FAIL] = supplyTripReset;
		flagSet[sfy_pkg::FLAG_LATE_WD] = sup.lateWdFault;
		flagSet[sfy_pkg::FLAG_EARLY_WD] = sup.earlyWdFault;
	end

	// Writing one to a flag is ignored: software can only clear
	assign flagClr = wrFlags ?
		~regReq.wrData[sfy_pkg::FLAG_LSB +: sfy_pkg::NUM_FLAGS] : '0;

	// Each flag has its own storage, so causes never mask one another
	genvar gi;
	generate
		for (gi = 0; gi < sfy_pkg::NUM_FLAGS; gi++)
		begin : g_flag
			sfy_sticky_flag u_flag
			(
				.core_clk(core_clk),
				.resetn(resetn),
				.setPulse(flagSet[gi]),
				.clrPulse(flagClr[gi]),
				.flag(flagVec[gi])
			);
		end
	endgenerate

	assign flagsOut = flagVec;

	// Non-BCD year writes are dropped so the register always holds a legal year
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			year_reg <= sfy_pkg::YEAR_RESET;
		else if (regReq.wrEn && (regReq.addr == sfy_pkg::ADDR_YEAR) && yearValid(regReq.wrData))
			year_reg <= regReq.wrData;
	end

	// Out-of-range months are dropped rather than folded into range
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			month_reg <= sfy_pkg::MONTH_RESET;
		else if (regReq.wrEn && (regReq.addr == sfy_pkg::ADDR_MONTH) && monthValid(regReq.wrData))
			month_reg <= regReq.wrData;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rdData_reg <= sfy_pkg::READ_ZERO;
			rdValid_reg <= 1'b0;
		end
		else
		begin
			rdValid_reg <= regReq.rdEn;
			if (regReq.rdEn)
			begin
				case (regReq.addr)
					sfy_pkg::ADDR_FLAGS: rdData_reg <= {flagVec, 4'h0};
					sfy_pkg::ADDR_YEAR: rdData_reg <= year_reg;
					sfy_pkg::ADDR_MONTH: rdData_reg <= month_reg;
					default: rdData_reg <= sfy_pkg::READ_ZERO;
				endcase
			end
		end
	end

	assign regRdData = rdData_reg;
	assign regRdValid = rdValid_reg;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!resetn);

	a_supply_fail_set: assert property (
		supplyTripReset |=> flagVec[sfy_pkg::FLAG_SUPPLY_FAIL] ##1
			(flagVec[sfy_pkg::FLAG_SUPPLY_FAIL] || $past(wrFlags)))
		else $error("supply-fail flag not set by low-supply reset");

	a_manual_no_set: assert property (
		(sup.manualReset && !sup.supplyBelowTrip && !flagVec[sfy_pkg::FLAG_SUPPLY_FAIL])
			|=> !flagVec[sfy_pkg::FLAG_SUPPLY_FAIL])
		else $error("manual reset changed supply-fail flag");

	// Checked with the supply-fail flag in either state, so a set flag is covered too
	a_flags_indep: assert property (
		(sup.earlyWdFault && !supplyTripReset && !wrFlags)
			|=> flagVec[sfy_pkg::FLAG_EARLY_WD] &&
			$stable(flagVec[sfy_pkg::FLAG_SUPPLY_FAIL]))
		else $error("watchdog fault disturbed supply-fail flag");

	a_late_indep: assert property (
		(sup.lateWdFault && !supplyTripReset && !wrFlags)
			|=> flagVec[sfy_pkg::FLAG_LATE_WD] &&
			$stable(flagVec[sfy_pkg::FLAG_SUPPLY_FAIL]))
		else $error("late watchdog fault disturbed supply-fail flag");

	a_clear_by_zero: assert property (
		(wrFlags && !regReq.wrData[sfy_pkg::FLAG_LSB + sfy_pkg::FLAG_SUPPLY_FAIL]
			&& !supplyTripReset) |=> !flagVec[sfy_pkg::FLAG_SUPPLY_FAIL])
		else $error("zero write did not clear supply-fail flag");

	a_write_one_ignored: assert property (
		(wrFlags && !flagVec[sfy_pkg::FLAG_BACKUP_LOW] && !flagSet[sfy_pkg::FLAG_BACKUP_LOW])
			|=> !flagVec[sfy_pkg::FLAG_BACKUP_LOW])
		else $error("host write set backup-low flag");

	a_backup_low_set: assert property (
		(sup.onBackup && sup.backupBelowMin) |=> flagVec[sfy_pkg::FLAG_BACKUP_LOW])
		else $error("backup-low flag not set");

	a_backup_low_sticky: assert property (
		(flagVec[sfy_pkg::FLAG_BACKUP_LOW] && !wrFlags) |=> flagVec[sfy_pkg::FLAG_BACKUP_LOW])
		else $error("backup-low flag cleared without host write");

	a_month_range: assert property (
		monthValid(month_reg) && $stable(month_reg) or
			$past(regReq.wrEn && (regReq.addr == sfy_pkg::ADDR_MONTH)))
		else $error("month register out of range or changed without write");

	a_year_write: assert property (
		(regReq.wrEn && (regReq.addr == sfy_pkg::ADDR_YEAR) && yearValid(regReq.wrData))
			|=> (year_reg == $past(regReq.wrData)))
		else $error("year write not stored");

	a_read_flags: assert property (
		(regReq.rdEn && (regReq.addr == sfy_pkg::ADDR_FLAGS))
			|=> regRdValid && (regRdData == {$past(flagVec), 4'h0}))
		else $error("flag read returned wrong value");

	a_year_hold: assert property (
		!(regReq.wrEn && (regReq.addr == sfy_pkg::ADDR_YEAR) && yearValid(regReq.wrData))
			|=> $stable(year_reg))
		else $error("year register changed without a legal write");

	a_year_bcd: assert property (
		yearValid(year_reg))
		else $error("year register holds a non-BCD value");

	a_month_write: assert property (
		(regReq.wrEn && (regReq.addr == sfy_pkg::ADDR_MONTH) && monthValid(regReq.wrData))
			|=> (month_reg == $past(regReq.wrData)))
		else $error("month write not stored");

	a_read_valid: assert property (
		regRdValid == $past(regReq.rdEn))
		else $error("read valid not one cycle after read strobe");

	a_read_year: assert property (
		(regReq.rdEn && (regReq.addr == sfy_pkg::ADDR_YEAR))
			|=> regRdValid && (regRdData == $past(year_reg)))
		else $error("year read returned wrong value");

	a_read_month: assert property (
		(regReq.rdEn && (regReq.addr == sfy_pkg::ADDR_MONTH))
			|=> regRdValid && (regRdData == $past(month_reg)))
		else $error("month read returned wrong value");

	// Per-flag checks: an event beats a same-cycle clear, and only a host zero clears
	generate
		for (gi = 0; gi < sfy_pkg::NUM_FLAGS; gi++)
		begin : g_flag_chk
			a_set_wins: assert property (
				flagSet[gi] |=> flagVec[gi])
				else $error("flag set event lost");

			a_no_self_clear: assert property (
				(flagVec[gi] && !flagClr[gi]) |=> flagVec[gi])
				else $error("flag cleared without a host zero write");

			a_clear_works: assert property (
				(flagClr[gi] && !flagSet[gi]) |=> !flagVec[gi])
				else $error("host zero write did not clear flag");
		end
	endgenerate

endmodule : sfy_supervisor_regs

//--- sfy_host_model.sv
// Host side model: byte register port driver with start-up flag handling
`timescale 1ns/1ps
module sfy_host_model
(
	input wire logic core_clk,
	output sfy_pkg::sfy_reg_req_t regReq,
	input wire logic [7:0] regRdData,
	input wire logic regRdValid
);
	logic [7:0] fl;
	initial regReq = '0;

	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk);
		#1 regReq = '{1'b1, 1'b0, a, v};
		@(posedge core_clk);
		#1 regReq.wrEn = 1'b0;
	endtask : wr

	// A missing valid pulse turns the data unknown so the compare fails
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk);
		#1 regReq = '{1'b0, 1'b1, a, 8'h00};
		@(posedge core_clk);
		#1 regReq.rdEn = 1'b0;
		d = regRdValid ? regRdData : 8'hxx;
	endtask : rd

	task init;
		rd(sfy_pkg::ADDR_FLAGS, fl);
		if (fl[sfy_pkg::FLAG_LSB + sfy_pkg::FLAG_BACKUP_LOW] === 1'b1)
		begin
			wr(sfy_pkg::ADDR_YEAR, 8'h00);
			wr(sfy_pkg::ADDR_MONTH, 8'h01);
		end
		wr(sfy_pkg::ADDR_FLAGS, 8'h00);
	endtask : init
endmodule : sfy_host_model

//--- testbench.sv
// Self-checking bench for the supervisor flags and calendar registers
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
	$display("ERROR %0t: got %h expected %h", $time, (a), (e)); end end
module testbench;
	logic core_clk = 0;
	logic resetn = 0;
	logic resetOutN = 1;
	sfy_pkg::sfy_supervisor_t sup = '0;
	sfy_pkg::sfy_reg_req_t regReq;
	logic [7:0] regRdData;
	logic regRdValid;
	logic [3:0] flagsOut;
	logic [7:0] d;
	logic [7:0] badMonth [4] = '{8'h13, 8'h00, 8'h0a, 8'h21};
	int n_fail = 0;
	int checks = 0;

	always #25 core_clk = ~core_clk;

	sfy_supervisor_regs uut (.core_clk(core_clk), .resetn(resetn), .regReq(regReq),
		.regRdData(regRdData), .regRdValid(regRdValid), .resetOutN(resetOutN),
		.sup(sup), .flagsOut(flagsOut));
	sfy_host_model host (.core_clk(core_clk), .regReq(regReq),
		.regRdData(regRdData), .regRdValid(regRdValid));

	task conclude;
		$display("Checks %0d, errors %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	task chk_reg(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, d);
		`CHK(d, e)
	endtask : chk_reg

	// Event bits: early wd, late wd, below trip, manual, on backup, backup below min
	task ev(input logic [5:0] s, input logic r);
		@(posedge core_clk);
		#1 sup = s;
		resetOutN = r;
		@(posedge core_clk);
		#1 sup = '0;
		resetOutN = 1'b1;
	endtask : ev

	initial
	begin
		repeat (6) @(posedge core_clk);
		#1 resetn = 1'b1;
		chk_reg(8'h08, 8'h00);
		chk_reg(8'h07, 8'h01);
		chk_reg(8'h09, 8'h00);
		chk_reg(8'h0a, 8'h00);
		host.wr(8'h08, 8'h25);
		chk_reg(8'h08, 8'h25);
		host.wr(8'h08, 8'h3a);
		chk_reg(8'h08, 8'h25);
		host.wr(8'h07, 8'h12);
		chk_reg(8'h07, 8'h12);
		foreach (badMonth[i])
		begin
			host.wr(8'h07, badMonth[i]);
			chk_reg(8'h07, 8'h12);
		end
		ev(6'h04, 1'b0);
		`CHK(flagsOut, 4'h0)
		ev(6'h08, 1'b1);
		`CHK(flagsOut, 4'h0)
		ev(6'h08, 1'b0);
		`CHK(flagsOut, 4'h2)
		ev(6'h20, 1'b1);
		`CHK(flagsOut, 4'ha)
		ev(6'h10, 1'b1);
		`CHK(flagsOut, 4'he)
		ev(6'h02, 1'b1);
		ev(6'h01, 1'b1);
		`CHK(flagsOut, 4'he)
		ev(6'h03, 1'b1);
		`CHK(flagsOut, 4'hf)
		chk_reg(8'h09, 8'hf0);
		host.wr(8'h09, 8'hff);
		chk_reg(8'h09, 8'hf0);
		host.wr(8'h09, 8'h10);
		chk_reg(8'h09, 8'h10);
		host.init;
		chk_reg(8'h09, 8'h00);
		chk_reg(8'h08, 8'h00);
		host.wr(8'h09, 8'hff);
		chk_reg(8'h09, 8'h00);
		conclude;
	end

	// The sequence needs about 85 cycles; the 800-cycle limit leaves wide margin
	initial
	begin
		#40000;
		n_fail++;
		conclude;
	end
endmodule : testbench
